// *** conv_cfg_regs.sv ***
/*
 * Register bank and clock divider sync control of the converter.
 * Assumes the serial port pins and the sync and strap pins are asynchronous
 * to i_clk; all are oversampled through two flip-flops. The serial clock
 * must stay below roughly a tenth of i_clk.
 */
// How it works
// - Sync pulses do nothing while the master sync enable bit is clear.
// - Sync pulses reach the divider only while divider sync enable is set.
// - With both enables set and next-only clear, every pulse realigns.
// - With next-only also set, only the first pulse realigns the divider.
// - After that first realign, hardware clears divider sync enable.
// - Output standard is taken from the strap pin after reset.
// - Software may select LVDS outputs through the output type bit.
// - Input clock divides by the three-bit ratio plus one.
`timescale 1ns/1ps
module conv_cfg_regs
(
    input  wire logic        i_clk,          // Sample clock, 200 MHz
    input  wire logic        i_arst_n,       // Asynchronous reset, low
    input  wire logic        i_sclk,         // Serial port clock pin
    input  wire logic        i_port_select_n,// Serial port select, low
    input  wire logic        i_sdio,         // Serial data pin, input side
    input  wire logic        i_sync,         // External sync pin
    input  wire logic        i_output_select,// Output standard strap pin
    input  wire logic [15:0] i_signature,    // Self-test signature
    output logic             o_sdio,         // Serial data pin, output side
    output logic             o_sdio_oe,      // Serial data drive enable
    output logic             o_div_tick,     // Divided clock enable pulse
    output logic             o_lvds_mode,    // 1 = LVDS, 0 = CMOS
    output logic             o_dither_en,    // Dither enable
    output logic [1:0]       o_ref_range,    // Reference range select
    output logic [4:0]       o_clk_delay,    // Output clock delay code
    output logic             o_sync_active   // Sync logic powered
);

    typedef struct packed {
        logic [1:0]  sclk_s;
        logic        sclk_d;
        logic [1:0]  csn_s;
        logic [1:0]  sdi_s;
        logic [1:0]  sync_s;
        logic        sync_d;
        logic [1:0]  strap_s;
        logic [1:0]  strap_cnt;
        logic        strap_done;
        logic [4:0]  bit_cnt;
        logic [15:0] instr;
        logic [7:0]  wdata;
        logic [7:0]  rdata;
        logic        sdo;
        logic        sdo_oe;
        logic [7:0]  clk_div;
        logic [7:0]  out_mode;
        logic [7:0]  clk_delay;
        logic [7:0]  ref_range;
        logic [7:0]  dither;
        logic [2:0]  sync_ctl;
        logic [15:0] sig;
        logic [2:0]  div_cnt;
        logic        div_tick;
    } state_s;

    state_s r;
    state_s next_r;
    logic [1:0] rst_s;
    logic       rst_n;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       sync_edge;
    logic       realign;
    logic       wr_commit;

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            rst_s <= 2'h0;
        else
            rst_s <= {rst_s[0], 1'b1};
    end
    assign rst_n = rst_s[1];

    // Read mux; bits 7 to 3 of sync control are not stored at all.
    function automatic logic [7:0] read_reg(input state_s s,
                                            input logic [12:0] a);
        case (a)
            conv_cfg_pkg::ADDR_CLOCK_DIVIDE:     read_reg = s.clk_div;
            conv_cfg_pkg::ADDR_OUTPUT_MODE:      read_reg = s.out_mode;
            conv_cfg_pkg::ADDR_OUTPUT_CLK_DELAY: read_reg = s.clk_delay;
            conv_cfg_pkg::ADDR_REF_RANGE:        read_reg = s.ref_range;
            conv_cfg_pkg::ADDR_SIG_LOW:          read_reg = s.sig[7:0];
            conv_cfg_pkg::ADDR_SIG_HIGH:         read_reg = s.sig[15:8];
            conv_cfg_pkg::ADDR_DITHER:           read_reg = s.dither;
            conv_cfg_pkg::ADDR_SYNC_CTL:
                read_reg = {5'h00, s.sync_ctl};
            default:                             read_reg = 8'h00;
        endcase
    endfunction

    assign sclk_rise = r.sclk_s[1] & ~r.sclk_d;
    assign sclk_fall = ~r.sclk_s[1] & r.sclk_d;
    assign sync_edge = r.sync_s[1] & ~r.sync_d;
    assign wr_commit = ~r.csn_s[1] & sclk_rise
                       & (r.bit_cnt == conv_cfg_pkg::LAST_BIT)
                       & ~r.instr[15];
    assign realign = sync_edge
                     & r.sync_ctl[conv_cfg_pkg::BIT_MASTER_SYNC]
                     & r.sync_ctl[conv_cfg_pkg::BIT_DIV_SYNC];

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        logic [12:0] a;
        logic [7:0]  d;
        a = r.instr[12:0];
        d = {r.wdata[6:0], r.sdi_s[1]};
        next_r = r;
        next_r.sclk_s  = {r.sclk_s[0], i_sclk};
        next_r.sclk_d  = r.sclk_s[1];
        next_r.csn_s   = {r.csn_s[0], i_port_select_n};
        next_r.sdi_s   = {r.sdi_s[0], i_sdio};
        next_r.sync_s  = {r.sync_s[0], i_sync};
        next_r.sync_d  = r.sync_s[1];
        next_r.strap_s = {r.strap_s[0], i_output_select};
        next_r.sig     = i_signature;

        // Strap is caught once the synchroniser has filled after reset.
        if (!r.strap_done)
        begin
            if (r.strap_cnt == conv_cfg_pkg::STRAP_SETTLE)
            begin
                next_r.strap_done = 1'b1;
                next_r.out_mode[conv_cfg_pkg::BIT_OUTPUT_TYPE] =
                    r.strap_s[1];
            end
            else
                next_r.strap_cnt = r.strap_cnt + 2'h1;
        end

        // Input clock divider.
        if (realign)
            next_r.div_cnt = 3'h0;
        else if (r.div_cnt == r.clk_div[conv_cfg_pkg::DIV_RATIO_MSB:0])
            next_r.div_cnt = 3'h0;
        else
            next_r.div_cnt = r.div_cnt + 3'h1;
        next_r.div_tick = (next_r.div_cnt == 3'h0);
        if (realign && r.sync_ctl[conv_cfg_pkg::BIT_NEXT_ONLY])
            next_r.sync_ctl[conv_cfg_pkg::BIT_DIV_SYNC] = 1'b0;

        // Serial port: sample on rising sclk, shift out on falling sclk.
        if (r.csn_s[1])
        begin
            next_r.bit_cnt = 5'h00;
            next_r.sdo_oe  = 1'b0;
        end
        else
        begin
            if (sclk_rise)
            begin
                if (r.bit_cnt < conv_cfg_pkg::INSTR_BITS)
                    next_r.instr = {r.instr[14:0], r.sdi_s[1]};
                else
                    next_r.wdata = d;
                if (r.bit_cnt != conv_cfg_pkg::LAST_BIT)
                    next_r.bit_cnt = r.bit_cnt + 5'h01;
            end
            if (sclk_fall && r.instr[15]
                && r.bit_cnt >= conv_cfg_pkg::INSTR_BITS)
            begin
                if (r.bit_cnt == conv_cfg_pkg::INSTR_BITS && !r.sdo_oe)
                begin
                    next_r.rdata  = {read_reg(r, a)} << 1;
                    next_r.sdo    = read_reg(r, a) >> 7 != 8'h00;
                    next_r.sdo_oe = 1'b1;
                end
                else
                begin
                    next_r.sdo   = r.rdata[7];
                    next_r.rdata = {r.rdata[6:0], 1'b0};
                end
            end
        end

        // A write landing with the hardware clear wins: it is newer intent.
        if (wr_commit)
        begin
            case (a)
                conv_cfg_pkg::ADDR_CLOCK_DIVIDE:     next_r.clk_div   = d;
                conv_cfg_pkg::ADDR_OUTPUT_MODE:
                    next_r.out_mode = d;
                conv_cfg_pkg::ADDR_OUTPUT_CLK_DELAY: next_r.clk_delay = d;
                conv_cfg_pkg::ADDR_REF_RANGE:        next_r.ref_range = d;
                conv_cfg_pkg::ADDR_DITHER:           next_r.dither    = d;
                conv_cfg_pkg::ADDR_SYNC_CTL:
                    next_r.sync_ctl = d[2:0];
                default:
                    next_r.sig = i_signature;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r           <= '0;
            r.csn_s     <= 2'h3;
            r.clk_div   <= conv_cfg_pkg::RST_CLOCK_DIVIDE;
            r.out_mode  <= conv_cfg_pkg::RST_OUTPUT_MODE;
            r.clk_delay <= conv_cfg_pkg::RST_OUTPUT_CLK_DELAY;
            r.ref_range <= conv_cfg_pkg::RST_REF_RANGE;
            r.dither    <= conv_cfg_pkg::RST_DITHER;
            r.sync_ctl  <= conv_cfg_pkg::RST_SYNC_CTL;
        end
        else
            r <= next_r;
    end

    assign o_sdio        = r.sdo;
    assign o_sdio_oe     = r.sdo_oe;
    assign o_div_tick    = r.div_tick;
    assign o_lvds_mode   = r.out_mode[conv_cfg_pkg::BIT_OUTPUT_TYPE];
    assign o_dither_en   = r.dither[conv_cfg_pkg::BIT_DITHER];
    assign o_ref_range   = r.ref_range[7:conv_cfg_pkg::REF_LSB];
    assign o_clk_delay   = r.clk_delay[conv_cfg_pkg::DELAY_MSB:0];
    assign o_sync_active = r.sync_ctl[conv_cfg_pkg::BIT_MASTER_SYNC];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);

    logic [2:0] ratio;
    logic [7:0] sync_rd;
    assign ratio   = r.clk_div[conv_cfg_pkg::DIV_RATIO_MSB:0];
    assign sync_rd = read_reg(r, conv_cfg_pkg::ADDR_SYNC_CTL);

    sequence free_step;
        sync_edge && r.div_cnt < ratio;
    endsequence
    sequence first_realign;
        realign && r.sync_ctl[conv_cfg_pkg::BIT_NEXT_ONLY] && !wr_commit;
    endsequence

    a_master_gate_off: assert property (free_step and !o_sync_active
        |=> r.div_cnt == $past(r.div_cnt) + 3'h1)
        else $error("Sync pulse acted while master sync was off.");
    a_div_gate_off: assert property (free_step and o_sync_active
        and !r.sync_ctl[conv_cfg_pkg::BIT_DIV_SYNC]
        |=> r.div_cnt == $past(r.div_cnt) + 3'h1)
        else $error("Sync pulse passed with divider sync off.");
    a_cont_realign: assert property (realign
        && !r.sync_ctl[conv_cfg_pkg::BIT_NEXT_ONLY] && !wr_commit
        |=> r.div_cnt == 3'h0 && o_div_tick
            && r.sync_ctl[conv_cfg_pkg::BIT_DIV_SYNC])
        else $error("Continuous sync did not realign the divider.");
    a_first_only: assert property (first_realign
        |=> r.div_cnt == 3'h0 ##0 !realign [*2])
        else $error("Next-only sync did not stop after first pulse.");
    a_self_clear: assert property (first_realign
        |=> !sync_rd[conv_cfg_pkg::BIT_DIV_SYNC])
        else $error("Divider sync enable not cleared after sync.");
    a_strap_load: assert property (!r.strap_done
        && r.strap_cnt == conv_cfg_pkg::STRAP_SETTLE
        |=> o_lvds_mode == $past(r.strap_s[1]) && r.strap_done)
        else $error("Output standard strap not captured.");
    a_lvds_write: assert property (wr_commit
        && r.instr[12:0] == conv_cfg_pkg::ADDR_OUTPUT_MODE
        |=> o_lvds_mode == $past(r.wdata[5]))
        else $error("Output type write not applied.");
    a_ratio_wrap: assert property (r.div_cnt == ratio && !realign
        |=> r.div_cnt == 3'h0 && o_div_tick
            ##1 ($past(ratio) == 3'h0 || $past(realign) || !o_div_tick))
        else $error("Divider did not wrap at ratio plus one.");
    a_reserved_zero: assert property (sync_rd[7:3] == 5'h00)
        else $error("Reserved sync control bits read nonzero.");

endmodule

// *** conv_cfg_pkg.sv ***
/*
 * Constants shared by the converter configuration register bank:
 * register addresses, field positions, reset values and serial-port framing.
 * Assumes a 13-bit register address carried in a 16-bit instruction word.
 */
package conv_cfg_pkg;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [12:0] ADDR_CLOCK_DIVIDE     = 13'h00b;
    localparam logic [12:0] ADDR_OUTPUT_MODE      = 13'h014;
    localparam logic [12:0] ADDR_OUTPUT_CLK_DELAY = 13'h017;
    localparam logic [12:0] ADDR_REF_RANGE        = 13'h018;
    localparam logic [12:0] ADDR_SIG_LOW          = 13'h024;
    localparam logic [12:0] ADDR_SIG_HIGH         = 13'h025;
    localparam logic [12:0] ADDR_DITHER           = 13'h030;
    localparam logic [12:0] ADDR_SYNC_CTL         = 13'h100;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_CLOCK_DIVIDE     = 8'h00;
    localparam logic [7:0] RST_OUTPUT_MODE      = 8'h00;
    localparam logic [7:0] RST_OUTPUT_CLK_DELAY = 8'h00;
    localparam logic [7:0] RST_REF_RANGE        = 8'hc0;
    localparam logic [7:0] RST_DITHER           = 8'h00;
    localparam logic [2:0] RST_SYNC_CTL         = 3'h0;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_MASTER_SYNC   = 0;
    localparam int BIT_DIV_SYNC      = 1;
    localparam int BIT_NEXT_ONLY     = 2;
    localparam int BIT_OUTPUT_TYPE   = 6;
    localparam int BIT_DITHER        = 4;
    localparam int DIV_RATIO_MSB     = 2;
    localparam int DELAY_MSB         = 4;
    localparam int REF_LSB           = 6;

    // ------------------------------------------------------------------
    // Serial frame: 16 instruction bits then 8 data bits, MSB first
    // ------------------------------------------------------------------
    localparam logic [4:0] INSTR_BITS   = 5'h10;
    localparam logic [4:0] LAST_BIT     = 5'h17;
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

endpackage

// *** spi_host_model.sv ***
/*
 * Host side of the converter: serial port master and external sync source.
 * Assumes the caller gives the sample clock; all pins change on its fall.
 */
`timescale 1ns/1ps
module spi_host_model
(
    input  wire logic i_clk,   // Sample clock
    input  wire logic i_sdio,  // Resolved serial data wire
    output logic      o_sclk,  // Serial clock, still outside frames
    output logic      o_sel_n, // Port select, low
    output logic      o_sdio,  // Host data drive
    output logic      o_sync   // External sync pin
);
    // ------------------------------------------------------------------
    // Frame engine
    // ------------------------------------------------------------------
    // Ten sample clocks a half period keeps well clear of the oversampler.
    localparam int HALF = 10;

    initial
    begin
        o_sclk  = 1'b0;
        o_sel_n = 1'b1;
        o_sdio  = 1'b0;
        o_sync  = 1'b0;
    end

    task automatic xfer(input logic rd, input logic [12:0] a,
                        input logic [7:0] wd, output logic [7:0] rdat);
        logic [23:0] w;
        w = {rd, 2'h0, a, wd};
        rdat = 8'h00;
        o_sel_n = 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            // A released line toggles, so a stale level is never read.
            o_sdio = (rd && i < 8) ? ~o_sdio : w[i];
            repeat (HALF) @(negedge i_clk);
            o_sclk = 1'b1;
            if (i < 8)
                rdat[i] = i_sdio;
            repeat (HALF) @(negedge i_clk);
            o_sclk = 1'b0;
        end
        repeat (HALF) @(negedge i_clk);
        o_sel_n = 1'b1;
        o_sdio  = ~o_sdio;
        repeat (HALF) @(negedge i_clk);
    endtask

    task automatic sync_level(input logic v);
        o_sync = v;
    endtask
endmodule

// *** testbench.sv ***
/*
 * Self-checking bench for the converter register bank and sync control.
 * Assumes the host model owns the serial and sync pins.
 */
`timescale 1ns/1ps
module testbench;
    logic        i_clk, i_arst_n, i_output_select;
    logic [15:0] i_signature;
    logic        sclk, sel_n, host_sdio, sync, sdio_wire;
    logic        o_sdio, o_sdio_oe, o_div_tick, o_lvds_mode;
    logic        o_dither_en, o_sync_active;
    logic [1:0]  o_ref_range;
    logic [4:0]  o_clk_delay;
    int          mismatches;
    int          checks_done;

    assign sdio_wire = o_sdio_oe ? o_sdio : host_sdio;

    spi_host_model host (.i_clk(i_clk), .i_sdio(sdio_wire), .o_sclk(sclk),
        .o_sel_n(sel_n), .o_sdio(host_sdio), .o_sync(sync));

    conv_cfg_regs dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_sclk(sclk),
        .i_port_select_n(sel_n), .i_sdio(sdio_wire), .i_sync(sync),
        .i_output_select(i_output_select), .i_signature(i_signature),
        .o_sdio(o_sdio), .o_sdio_oe(o_sdio_oe), .o_div_tick(o_div_tick),
        .o_lvds_mode(o_lvds_mode), .o_dither_en(o_dither_en),
        .o_ref_range(o_ref_range), .o_clk_delay(o_clk_delay),
        .o_sync_active(o_sync_active));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] x;
        host.xfer(1'b0, a, d, x);
    endtask

    task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
        logic [7:0] x;
        host.xfer(1'b1, a, 8'h00, x);
        check($sformatf("reg %h", a), x, exp);
        check("sdio released", {7'h0, o_sdio_oe}, 8'h00);
    endtask

    task automatic do_reset(input logic strap);
        i_output_select = strap;
        i_arst_n = 1'b0;
        repeat (5) @(negedge i_clk);
        i_arst_n = 1'b1;
        repeat (12) @(negedge i_clk);
    endtask

    // Counts falling edges from the current point to the next divider tick.
    task automatic to_tick(output int n);
        n = 0;
        do
        begin
            @(negedge i_clk);
            n++;
        end
        while (o_div_tick !== 1'b1 && n < 20);
    endtask

    task automatic period(input logic [2:0] r);
        int n;
        wr(conv_cfg_pkg::ADDR_CLOCK_DIVIDE, {5'h0, r});
        to_tick(n);
        to_tick(n);
        check("divider period", n[7:0], {5'h0, r} + 8'h01);
    endtask

    // Raises sync on the falling edge of a tick; a realign comes far before the
    // natural tick eight cycles on, so an early tick means it was taken.
    task automatic probe(input logic exp);
        int n;
        to_tick(n);
        host.sync_level(1'b1);
        to_tick(n);
        host.sync_level(1'b0);
        check("realigned", {7'h0, n < 7}, {7'h0, exp});
        repeat (12) @(negedge i_clk);
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock, watchdog and tests
    // ------------------------------------------------------------------
    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    initial
    begin
        #300000;
        mismatches++;
        conclude();
    end

    initial
    begin
        mismatches = 0;
        checks_done = 0;
        i_arst_n = 1'b0;
        i_output_select = 1'b1;
        i_signature = 16'ha55a;
        do_reset(1'b1);
        check("lvds strap", {7'h0, o_lvds_mode}, 8'h01);
        check("ref range", {6'h0, o_ref_range}, 8'h03);
        rd_chk(conv_cfg_pkg::ADDR_REF_RANGE, 8'hc0);
        rd_chk(conv_cfg_pkg::ADDR_DITHER, 8'h00);
        rd_chk(conv_cfg_pkg::ADDR_SYNC_CTL, 8'h00);
        rd_chk(conv_cfg_pkg::ADDR_OUTPUT_CLK_DELAY, 8'h00);
        $display("test reset values done");

        wr(conv_cfg_pkg::ADDR_DITHER, 8'h10);
        check("dither", {7'h0, o_dither_en}, 8'h01);
        rd_chk(conv_cfg_pkg::ADDR_DITHER, 8'h10);
        wr(conv_cfg_pkg::ADDR_OUTPUT_CLK_DELAY, 8'h1f);
        check("clock delay", {3'h0, o_clk_delay}, 8'h1f);
        wr(conv_cfg_pkg::ADDR_REF_RANGE, 8'h40);
        check("ref range", {6'h0, o_ref_range}, 8'h01);
        wr(conv_cfg_pkg::ADDR_SIG_LOW, 8'hff);
        rd_chk(conv_cfg_pkg::ADDR_SIG_LOW, 8'h5a);
        rd_chk(conv_cfg_pkg::ADDR_SIG_HIGH, 8'ha5);
        rd_chk(13'h1ff, 8'h00);
        $display("test access kinds done");

        do_reset(1'b0);
        check("cmos strap", {7'h0, o_lvds_mode}, 8'h00);
        wr(conv_cfg_pkg::ADDR_OUTPUT_MODE, 8'h40);
        check("lvds by port", {7'h0, o_lvds_mode}, 8'h01);
        $display("test output standard done");

        period(3'h0);
        period(3'h1);
        period(3'h7);
        $display("test divider done");

        wr(conv_cfg_pkg::ADDR_SYNC_CTL, 8'hf8);
        rd_chk(conv_cfg_pkg::ADDR_SYNC_CTL, 8'h00);
        probe(1'b0);
        wr(conv_cfg_pkg::ADDR_SYNC_CTL, 8'h02);
        check("sync power", {7'h0, o_sync_active}, 8'h00);
        probe(1'b0);
        wr(conv_cfg_pkg::ADDR_SYNC_CTL, 8'h01);
        check("sync power", {7'h0, o_sync_active}, 8'h01);
        probe(1'b0);
        wr(conv_cfg_pkg::ADDR_SYNC_CTL, 8'h03);
        probe(1'b1);
        probe(1'b1);
        rd_chk(conv_cfg_pkg::ADDR_SYNC_CTL, 8'h03);
        wr(conv_cfg_pkg::ADDR_SYNC_CTL, 8'h07);
        probe(1'b1);
        rd_chk(conv_cfg_pkg::ADDR_SYNC_CTL, 8'h05);
        probe(1'b0);
        wr(conv_cfg_pkg::ADDR_SYNC_CTL, 8'h00);
        $display("test sync control done");
        conclude();
    end
endmodule
